/* File: logic/hpdmp_cfg_bank.sv */
// Purpose: port disable and max power configuration bytes for the hub
// Assumes: loader writes bytes, then pulses load_done_i; power flag is local
// Notes: selected settings are frozen at load done, held until next reset
`timescale 1ns/100ps
module hpdmp_cfg_bank #(
  parameter int unsigned NPORT = hpdmp_pkg::NUM_PORTS
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire hpdmp_pkg::hpdmp_wr_s wr_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  input wire logic image_valid_i,
  input wire logic load_done_i,
  input wire logic power_self_i,
  output logic cfg_valid_o,
  output hpdmp_pkg::hpdmp_cfg_s cfg_o,
  output logic [NPORT*2-1:0] port_lnum_o
);
  logic [7:0] pds_q;
  logic [7:0] pdb_q;
  logic [7:0] mps_q;
  logic [7:0] mpb_q;
  logic valid_q;
  hpdmp_pkg::hpdmp_cfg_s cfg_q;
  logic [NPORT*2-1:0] lnum_q;
  logic [7:0] mask_sel;
  logic [NPORT-1:0] en_sel;
  logic [1:0] cnt_sel;
  logic [NPORT*2-1:0] lnum_sel;
  logic wr_ok;

  // writes accepted only before freeze and only with a valid image
  assign wr_ok = wr_i.we && image_valid_i && !valid_q;

  // storage; reserved bits masked on write so a written disable byte reads them as zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pds_q <= hpdmp_pkg::RST_PORT_DISABLE;
      pdb_q <= hpdmp_pkg::RST_PORT_DISABLE;
      mps_q <= hpdmp_pkg::RST_MAX_POWER_SELF;
      mpb_q <= hpdmp_pkg::RST_MAX_POWER_BUS;
    end else if (wr_ok) begin
      unique case (wr_i.addr)
        hpdmp_pkg::OFS_PORT_DISABLE_SELF: pds_q <= wr_i.data & hpdmp_pkg::PORT_DISABLE_MASK;
        hpdmp_pkg::OFS_PORT_DISABLE_BUS: pdb_q <= wr_i.data & hpdmp_pkg::PORT_DISABLE_MASK;
        hpdmp_pkg::OFS_MAX_POWER_SELF: mps_q <= wr_i.data;
        hpdmp_pkg::OFS_MAX_POWER_BUS: mpb_q <= wr_i.data;
        default: ;
      endcase
    end
  end

  // read back; unmapped offsets return zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      unique case (rd_addr_i)
        hpdmp_pkg::OFS_PORT_DISABLE_SELF: rd_data_o <= pds_q;
        hpdmp_pkg::OFS_PORT_DISABLE_BUS: rd_data_o <= pdb_q;
        hpdmp_pkg::OFS_MAX_POWER_SELF: rd_data_o <= mps_q;
        hpdmp_pkg::OFS_MAX_POWER_BUS: rd_data_o <= mpb_q;
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

  // mode select; reserved bits cannot leak since only bits 3..1 are used
  assign mask_sel = (power_self_i == hpdmp_pkg::POWER_SELF) ? pds_q : pdb_q;
  assign en_sel = ~mask_sel[hpdmp_pkg::PORT_BIT_LO +: NPORT];

  hpdmp_port_map #(
    .NPORT(NPORT)
  ) hpdmp_port_map_inst (
    .port_en_i(en_sel),
    .count_o(cnt_sel),
    .lnum_o(lnum_sel)
  );

  // freeze at load done so the host sees a stable hub during enumeration
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      valid_q <= 1'b0;
      cfg_q <= '0;
      lnum_q <= '0;
    end else if (load_done_i && !valid_q) begin
      valid_q <= 1'b1;
      cfg_q.port_en <= en_sel;
      cfg_q.port_count <= cnt_sel;
      cfg_q.max_power <= (power_self_i == hpdmp_pkg::POWER_SELF) ? mps_q : mpb_q;
      lnum_q <= lnum_sel;
    end
  end

  assign cfg_valid_o = valid_q;
  assign cfg_o = cfg_q;
  assign port_lnum_o = lnum_q;

  // the 30h default carries two reserved bits, so only bits neither written nor defaulted must stay 0
  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (srst_i)
      ((pds_q | pdb_q) &
        ~(hpdmp_pkg::PORT_DISABLE_MASK | hpdmp_pkg::RST_PORT_DISABLE)) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      valid_q |=> $stable(cfg_q) && $stable(lnum_q) && valid_q;
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed after freeze");

  property p_latch_self;
    @(posedge clk_sys_i) disable iff (srst_i)
      (load_done_i && !valid_q && power_self_i) |=>
        cfg_q.max_power == $past(mps_q) && cfg_q.port_en == ~$past(pds_q[3:1]);
  endproperty
  a_latch_self: assert property (p_latch_self) else $error("self settings wrong");

  property p_latch_bus;
    @(posedge clk_sys_i) disable iff (srst_i)
      (load_done_i && !valid_q && !power_self_i) |=>
        cfg_q.max_power == $past(mpb_q) && cfg_q.port_en == ~$past(pdb_q[3:1]);
  endproperty
  a_latch_bus: assert property (p_latch_bus) else $error("bus settings wrong");

  property p_count;
    @(posedge clk_sys_i) disable iff (srst_i)
      valid_q |-> cfg_q.port_count == 2'($countones(cfg_q.port_en));
  endproperty
  a_count: assert property (p_count) else $error("port count mismatch");

  property p_no_image;
    @(posedge clk_sys_i) disable iff (srst_i)
      (wr_i.we && !image_valid_i) |=>
        $stable(pds_q) && $stable(pdb_q) && $stable(mps_q) && $stable(mpb_q);
  endproperty
  a_no_image: assert property (p_no_image) else $error("write without valid image");

  property p_disabled_hidden;
    @(posedge clk_sys_i) disable iff (srst_i)
      (valid_q && !cfg_q.port_en[0]) |-> lnum_q[1:0] == 2'h0;
  endproperty
  a_disabled_hidden: assert property (p_disabled_hidden) else $error("disabled port numbered");

  property p_first_num;
    @(posedge clk_sys_i) disable iff (srst_i)
      (valid_q && cfg_q.port_en[0]) |-> lnum_q[1:0] == 2'h1;
  endproperty
  a_first_num: assert property (p_first_num) else $error("port 1 not numbered one");

  // sync reset restores the built-in bytes and drops any frozen settings
  property p_reset_defaults;
    @(posedge clk_sys_i)
      srst_i |=> pds_q == hpdmp_pkg::RST_PORT_DISABLE &&
        pdb_q == hpdmp_pkg::RST_PORT_DISABLE && mps_q == hpdmp_pkg::RST_MAX_POWER_SELF &&
        mpb_q == hpdmp_pkg::RST_MAX_POWER_BUS && !valid_q;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults lost");

  // first done always freezes; nothing shows before that so the host sees no half state
  property p_valid_rise;
    @(posedge clk_sys_i) disable iff (srst_i)
      (load_done_i && !valid_q) |=> valid_q;
  endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("freeze missed");

  property p_pre_freeze;
    @(posedge clk_sys_i) disable iff (srst_i)
      !valid_q |-> (cfg_q == '0) && (lnum_q == '0);
  endproperty
  a_pre_freeze: assert property (p_pre_freeze) else $error("settings shown before freeze");

  // accepted writes land as given, disable bytes with reserved bits cleared
  property p_wr_pds;
    @(posedge clk_sys_i) disable iff (srst_i)
      (wr_ok && wr_i.addr == hpdmp_pkg::OFS_PORT_DISABLE_SELF) |=>
        pds_q == ($past(wr_i.data) & hpdmp_pkg::PORT_DISABLE_MASK);
  endproperty
  a_wr_pds: assert property (p_wr_pds) else $error("self disable write wrong");

  property p_wr_pdb;
    @(posedge clk_sys_i) disable iff (srst_i)
      (wr_ok && wr_i.addr == hpdmp_pkg::OFS_PORT_DISABLE_BUS) |=>
        pdb_q == ($past(wr_i.data) & hpdmp_pkg::PORT_DISABLE_MASK);
  endproperty
  a_wr_pdb: assert property (p_wr_pdb) else $error("bus disable write wrong");

  property p_wr_mps;
    @(posedge clk_sys_i) disable iff (srst_i)
      (wr_ok && wr_i.addr == hpdmp_pkg::OFS_MAX_POWER_SELF) |=>
        mps_q == $past(wr_i.data);
  endproperty
  a_wr_mps: assert property (p_wr_mps) else $error("self power write wrong");

  property p_wr_mpb;
    @(posedge clk_sys_i) disable iff (srst_i)
      (wr_ok && wr_i.addr == hpdmp_pkg::OFS_MAX_POWER_BUS) |=>
        mpb_q == $past(wr_i.data);
  endproperty
  a_wr_mpb: assert property (p_wr_mpb) else $error("bus power write wrong");

  // read data is one cycle behind the offset, so compare with the byte as it stood then
  property p_rd_pds;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rd_addr_i == hpdmp_pkg::OFS_PORT_DISABLE_SELF) |=> rd_data_o == $past(pds_q);
  endproperty
  a_rd_pds: assert property (p_rd_pds) else $error("self disable read wrong");

  property p_rd_pdb;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rd_addr_i == hpdmp_pkg::OFS_PORT_DISABLE_BUS) |=> rd_data_o == $past(pdb_q);
  endproperty
  a_rd_pdb: assert property (p_rd_pdb) else $error("bus disable read wrong");

  property p_rd_mps;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rd_addr_i == hpdmp_pkg::OFS_MAX_POWER_SELF) |=> rd_data_o == $past(mps_q);
  endproperty
  a_rd_mps: assert property (p_rd_mps) else $error("self power read wrong");

  property p_rd_mpb;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rd_addr_i == hpdmp_pkg::OFS_MAX_POWER_BUS) |=> rd_data_o == $past(mpb_q);
  endproperty
  a_rd_mpb: assert property (p_rd_mpb) else $error("bus power read wrong");

  c_self: cover property (@(posedge clk_sys_i) load_done_i && !valid_q && power_self_i);
  c_bus: cover property (@(posedge clk_sys_i) load_done_i && !valid_q && !power_self_i);
  c_write: cover property (@(posedge clk_sys_i) wr_ok);
  c_one_port: cover property (@(posedge clk_sys_i) valid_q && cfg_q.port_count == 2'h1);
  c_no_image: cover property (@(posedge clk_sys_i) wr_i.we && !image_valid_i);
endmodule // hpdmp_cfg_bank

/* File: logic/hpdmp_pkg.sv */
// Purpose: shared constants and carriers for the port disable / max power bank
// Assumes: byte-wide configuration loader writes offsets 0x2a..0x2d
// Notes: reset values are the built-in defaults used without a valid image
package hpdmp_pkg;
  localparam int unsigned NUM_PORTS = 3;
  localparam logic [7:0] OFS_PORT_DISABLE_SELF = 8'h2a;
  localparam logic [7:0] OFS_PORT_DISABLE_BUS = 8'h2b;
  localparam logic [7:0] OFS_MAX_POWER_SELF = 8'h2c;
  localparam logic [7:0] OFS_MAX_POWER_BUS = 8'h2d;
  localparam logic [7:0] RST_PORT_DISABLE = 8'h30;
  localparam logic [7:0] RST_MAX_POWER_SELF = 8'h01;
  localparam logic [7:0] RST_MAX_POWER_BUS = 8'h00;
  // disable bits 3..1 map to ports 3..1; bit 0 and 7..4 reserved
  localparam logic [7:0] PORT_DISABLE_MASK = 8'h0e;
  localparam int unsigned PORT_BIT_LO = 1;
  localparam int unsigned MAX_POWER_UNIT_MA = 2;
  localparam logic POWER_SELF = 1'b1;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       we;
  } hpdmp_wr_s;

  typedef struct packed {
    logic [NUM_PORTS-1:0] port_en;
    logic [1:0]           port_count;
    logic [7:0]           max_power;
  } hpdmp_cfg_s;
endpackage

/* File: logic/hpdmp_port_map.sv */
// Purpose: count enabled ports and give each a contiguous logical number
// Assumes: enable vector bit i is physical port i+1
// Notes: logical number 0 means the port is not visible to the host
`timescale 1ns/100ps
module hpdmp_port_map #(
  parameter int unsigned NPORT = 3
) (
  input wire logic [NPORT-1:0] port_en_i,
  output logic [1:0] count_o,
  output logic [NPORT*2-1:0] lnum_o
);
  // running count renumbers active ports from 1 upward
  always_comb begin
    logic [1:0] cnt;
    cnt = 2'h0;
    lnum_o = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (port_en_i[i]) begin
        cnt = cnt + 2'h1;
        lnum_o[i*2 +: 2] = cnt;
      end
    end
    count_o = cnt;
  end
endmodule // hpdmp_port_map

/* File: verif/hpdmp_loader.sv */
// Purpose: configuration loader model that writes hub bytes one at a time
// Assumes: bytes change just after the falling edge of clk_sys_i
// Notes: released bus shows inverted values so stale data cannot pass
`timescale 1ns/100ps
module hpdmp_loader (
  input wire logic clk_sys_i,
  output hpdmp_pkg::hpdmp_wr_s wr_o
);
  initial wr_o = '0;
  // one-cycle strobe per byte; the writer clears reserved bit 0 and caps self power
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == 8'h2c && d > 8'h32) ? 8'h32 : d;
    if (a == 8'h2a || a == 8'h2b) v[0] = 1'b0;
    @(negedge clk_sys_i);
    wr_o = '{addr: a, data: v, we: 1'b1};
    @(negedge clk_sys_i);
    wr_o = '{addr: ~a, data: ~v, we: 1'b0};
  endtask
endmodule // hpdmp_loader

/* File: verif/hpdmp_cfg_bank_test.sv */
// Purpose: self-checking bench for the port disable / max power bank
// Assumes: inputs change at the falling edge, seed fixed at 60
// Notes: each pass resets, loads random bytes (all ones in the third pass), freezes and probes the hold
`timescale 1ns/100ps
module hpdmp_cfg_bank_test;
  logic clk_sys_i = 0, srst_i = 1, image_valid_i = 0, load_done_i = 0, power_self_i = 0;
  logic [7:0] rd_addr_i = 8'h00, rd_data_o;
  logic cfg_valid_o;
  logic [5:0] port_lnum_o;
  hpdmp_pkg::hpdmp_wr_s wr_i;
  hpdmp_pkg::hpdmp_cfg_s cfg_o;
  int seed = 60, error_cnt = 0, total_checks = 0, cyc = 0;
  logic [7:0] r [4];
  logic [31:0] v;
  logic [19:0] e;
  always #4 clk_sys_i = ~clk_sys_i;
  hpdmp_loader hpdmp_loader_inst (.clk_sys_i(clk_sys_i), .wr_o(wr_i));
  hpdmp_cfg_bank hpdmp_cfg_bank_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .wr_i(wr_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .image_valid_i(image_valid_i),
    .load_done_i(load_done_i), .power_self_i(power_self_i), .cfg_valid_o(cfg_valid_o),
    .cfg_o(cfg_o), .port_lnum_o(port_lnum_o));
  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // registered read data lands one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk_sys_i);
    rd_addr_i = a;
    @(negedge clk_sys_i);
    chk({12'h000, rd_data_o}, {12'h000, x});
  endtask
  // expected {valid, lnum, port_en, count, power}: set bit hides a port, rest numbered upward
  function automatic logic [19:0] exp_cfg(input logic [7:0] m, input logic [7:0] p);
    logic [2:0] en;
    logic [1:0] n;
    logic [5:0] ln;
    en = ~m[3:1];
    n = 2'h0;
    ln = 6'h00;
    for (int i = 0; i < 3; i++) begin
      if (en[i]) begin
        n++;
        ln[2*i +: 2] = n;
      end
    end
    return {1'b1, ln, en, n, p};
  endfunction
  // hang guard: a full run needs well under 1000 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    for (int k = 0; k < 10; k++) begin
      srst_i = 1;
      repeat (6) @(negedge clk_sys_i);
      srst_i = 0;
      image_valid_i = (k > 1); // first two passes write without a valid image
      r = '{8'h30, 8'h30, 8'h01, 8'h00};
      for (int a = 0; a < 4; a++) begin
        v = $random(seed);
        if (k == 2) v = 32'hffff_ffff; // every port masked off
        hpdmp_loader_inst.put(8'h2a + a[7:0], v[7:0]);
        if (k > 1) r[a] = (a < 2) ? (v[7:0] & 8'h0e) : (a == 2 && v[7:0] > 8'h32) ? 8'h32 : v[7:0];
      end
      for (int a = 0; a < 5; a++) rd(8'h2a + a[7:0], (a < 4) ? r[a] : 8'h00);
      chk({cfg_valid_o, port_lnum_o, cfg_o}, 20'h00000);
      v = $random(seed);
      // first two passes pin self then bus power so both default power bytes get reported
      power_self_i = (k < 2) ? ~k[0] : v[0];
      e = power_self_i ? exp_cfg(r[0], r[2]) : exp_cfg(r[1], r[3]);
      @(negedge clk_sys_i);
      load_done_i = 1;
      @(negedge clk_sys_i);
      load_done_i = 0;
      chk({cfg_valid_o, port_lnum_o, cfg_o}, e);
      // after freeze: writes, a flipped flag and a second done must change nothing
      power_self_i = ~power_self_i;
      hpdmp_loader_inst.put(8'h2c, 8'h11);
      load_done_i = 1;
      rd(8'h2c, r[2]);
      load_done_i = 0;
      chk({cfg_valid_o, port_lnum_o, cfg_o}, e);
    end
    close_out();
  end
endmodule // hpdmp_cfg_bank_test
